// File: shared/toc_pkg.sv
`default_nettype none
package toc_pkg;
  // register byte addresses
  localparam logic [7:0]  TOC_OFS_CTRL1   = 8'h00;
  localparam logic [7:0]  TOC_OFS_CTRL2   = 8'h04;
  localparam logic [7:0]  TOC_OFS_STATUS  = 8'h08;
  localparam logic [7:0]  TOC_OFS_C1_HIGH = 8'h0C;
  localparam logic [7:0]  TOC_OFS_C1_LOW  = 8'h10;
  localparam logic [7:0]  TOC_OFS_C2_HIGH = 8'h14;
  localparam logic [7:0]  TOC_OFS_C2_LOW  = 8'h18;
  // control one fields
  localparam int          TOC_IRQ_EN_BIT  = 0;
  localparam int          TOC_LEVEL_LSB   = 1;
  localparam int          TOC_FORCE_LSB   = 3;
  // control two fields
  localparam int          TOC_PIN_EN_LSB  = 0;
  localparam int          TOC_CLK_SEL_LSB = 2;
  localparam int          TOC_SPM_BIT     = 4;
  localparam int          TOC_PWM_BIT     = 5;
  // reset values and match lag
  localparam logic [15:0] TOC_CMP_RESET   = 16'h8000;
  localparam logic [15:0] TOC_MATCH_LAG   = 16'h0001;
  localparam logic [31:0] TOC_RD_ZERO     = 32'h0000_0000;

  typedef enum logic [1:0] {
    TOC_CLK_DIV2 = 2'b00,
    TOC_CLK_DIV4 = 2'b01,
    TOC_CLK_DIV8 = 2'b10,
    TOC_CLK_EXT  = 2'b11
  } toc_clk_e;

  typedef struct packed {
    logic       irq_en;
    logic [1:0] level;
    logic [1:0] pin_en;
    toc_clk_e   clk_sel;
    logic       single_pulse_mode;
    logic       pwm_mode;
  } toc_ctrl_s;

  typedef struct packed {
    logic       wr_hi;
    logic       wr_lo;
    logic       acc_lo;
    logic       sr_rd;
    logic       sr_seen;
    logic [7:0] wdata;
  } toc_acc_s;
endpackage
`default_nettype wire

// File: hdl/toc_chan.sv
`timescale 1ns/1ns
`default_nettype none
module toc_chan #(
  parameter bit DISABLED = 1'b0
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // register access
  input  wire toc_pkg::toc_acc_s acc,
  // timer side
  input  wire logic [15:0]       count,
  input  wire logic              tick,
  input  wire logic              div2,
  input  wire logic              pin_en,
  input  wire logic              level,
  input  wire logic              force_pulse,
  // results
  output logic [15:0]            value,
  output logic                   flag,
  output logic                   pin
);
  import toc_pkg::*;

  logic        inhibit;
  logic        armed;
  logic        match;
  logic [15:0] target;

  // slow prescalers see the counter one count late
  assign target = div2 ? value : value + TOC_MATCH_LAG; // [R13] [R14] [R18]
  // compare runs whatever the capture side does
  assign match  = ce && tick && !inhibit && !DISABLED && (count == target); // [R1] [R21] [R17]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= TOC_CMP_RESET; // [R6]
    end else if (ce) begin
      if (acc.wr_hi) value[15:8] <= acc.wdata; // [R7]
      if (acc.wr_lo) value[7:0]  <= acc.wdata; // [R7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit <= 1'b0;
    end else if (ce) begin
      if (acc.wr_lo) inhibit <= 1'b0; // [R10]
      else if (acc.wr_hi) inhibit <= 1'b1; // [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (ce) begin
      if (acc.acc_lo) armed <= 1'b0;
      else if (acc.sr_rd && acc.sr_seen) armed <= 1'b1; // [R23]
    end
  end

  // a match in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (match) flag <= 1'b1; // [R2]
      else if (acc.acc_lo && armed) flag <= 1'b0; // [R8] [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0; // [R4]
    end else if (ce) begin
      if (match && pin_en) pin <= level; // [R3] [R12]
      else if (force_pulse) pin <= level; // [R15]
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_on_match_a: assert property (match |=> flag) // [R2]
    else $error("flag not set after match");
  inhibit_hold_a: assert property ((ce && acc.wr_hi && !acc.wr_lo) |=> (inhibit && !match)) // [R9]
    else $error("match while high byte pending");
  arm_clear_a: assert property ((ce && armed && acc.acc_lo && !match) |=> !flag) // [R8]
    else $error("armed low access did not clear flag");
  unarmed_keep_a: assert property ((flag && !armed && !acc.sr_rd) |=> flag) // [R23]
    else $error("flag cleared without arming");
endmodule
`default_nettype wire

// File: hdl/toc_top.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// R1 - compare each channel every timer tick
// R2 - match sets the channel flag
// R3 - match drives pin with level bit
// R4 - pin latch low during reset
// R5 - interrupt needs enable set, mask clear
// R6 - compare values reset to 8000h
// R7 - compare values software owned, hardware untouched
// R8 - flag clears: status read, then low access
// R9 - high byte write inhibits matches
// R10 - low byte write re-enables, finishes clear
// R11 - software writes high, reads status, writes low
// R12 - pin disabled: no level, interrupt allowed
// R13 - divide by two: match at value
// R14 - slower clocks: match at value plus one
// R15 - force copies level, no flag, no irq
// R16 - force ignored in pulse or pwm mode
// R17 - reduced variant: channel two write-only, silent
// R18 - resolution one count of prescaled counter
// R19 - pin enable dedicates pin to channel
// R20 - software reloads compare after each match
// R21 - compare works alongside input capture
// R22 - both select bits one: external clock
// R23 - arm bit gates the low-access clear
module toc_top #(
  parameter bit REDUCED = 1'b0
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // counter and core
  input  wire logic [15:0] timer_count,
  input  wire logic        timer_tick,
  input  wire logic        irq_mask,
  // compare outputs
  output logic [1:0]       compare_output_pin,
  output logic [1:0]       compare_pin_oe,
  output logic             timer_irq
);
  import toc_pkg::*;

  toc_ctrl_s   ctrl;
  logic [1:0]  force_level;
  logic [1:0]  compare_match_flag;
  logic [15:0] compare_value_one;
  logic [15:0] compare_value_two;
  logic        err_q;
  logic        setup;
  logic        access;
  logic        hit;
  logic        wr;
  logic        rd;
  logic        wr_byte;
  logic        force_ok;
  logic        div2;
  logic [31:0] next_prdata;
  toc_acc_s    acc_one;
  toc_acc_s    acc_two;

  // bus phases; a low clock enable stretches the access
  assign setup   = psel && !penable;
  assign pready  = ce;
  assign access  = psel && penable && ce;
  assign wr      = access && pwrite && hit;
  assign rd      = access && !pwrite && hit;
  assign wr_byte = wr && pstrb[0];
  assign pslverr = psel && penable && err_q;

  always_comb begin
    case (paddr)
      TOC_OFS_CTRL1,
      TOC_OFS_CTRL2,
      TOC_OFS_STATUS,
      TOC_OFS_C1_HIGH,
      TOC_OFS_C1_LOW,
      TOC_OFS_C2_HIGH,
      TOC_OFS_C2_LOW: hit = 1'b1;
      default:        hit = 1'b0;
    endcase
  end

  // force bits always read as zero
  always_comb begin
    next_prdata = TOC_RD_ZERO;
    case (paddr)
      TOC_OFS_CTRL1: begin
        next_prdata[TOC_IRQ_EN_BIT] = ctrl.irq_en;
        next_prdata[TOC_LEVEL_LSB +: 2] = ctrl.level;
      end
      TOC_OFS_CTRL2: begin
        next_prdata[TOC_PIN_EN_LSB +: 2] = ctrl.pin_en;
        next_prdata[TOC_CLK_SEL_LSB +: 2] = ctrl.clk_sel;
        next_prdata[TOC_SPM_BIT] = ctrl.single_pulse_mode;
        next_prdata[TOC_PWM_BIT] = ctrl.pwm_mode;
      end
      TOC_OFS_STATUS: begin
        next_prdata[1:0] = compare_match_flag;
      end
      TOC_OFS_C1_HIGH: begin
        next_prdata[7:0] = compare_value_one[15:8];
      end
      TOC_OFS_C1_LOW: begin
        next_prdata[7:0] = compare_value_one[7:0];
      end
      TOC_OFS_C2_HIGH: begin
        if (!REDUCED) next_prdata[7:0] = compare_value_two[15:8]; // [R17]
      end
      TOC_OFS_C2_LOW: begin
        if (!REDUCED) next_prdata[7:0] = compare_value_two[7:0]; // [R17]
      end
      default: begin
        next_prdata = TOC_RD_ZERO;
      end
    endcase
  end

  // read data is taken in setup so it comes from a flop with no wait state;
  // the status arm step therefore uses the flag as it was returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= TOC_RD_ZERO;
    end else if (ce && setup) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (ce && setup) begin
      err_q <= !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else if (wr_byte && paddr == TOC_OFS_CTRL1) begin
      ctrl.irq_en <= pwdata[TOC_IRQ_EN_BIT];
      ctrl.level  <= pwdata[TOC_LEVEL_LSB +: 2];
    end else if (wr_byte && paddr == TOC_OFS_CTRL2) begin
      ctrl.pin_en            <= pwdata[TOC_PIN_EN_LSB +: 2];
      ctrl.clk_sel           <= toc_clk_e'(pwdata[TOC_CLK_SEL_LSB +: 2]);
      ctrl.single_pulse_mode <= pwdata[TOC_SPM_BIT];
      ctrl.pwm_mode          <= pwdata[TOC_PWM_BIT];
    end
  end

  assign force_ok = !ctrl.single_pulse_mode && !ctrl.pwm_mode; // [R16]

  // pulse one cycle after the write so the new level is already stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_level <= 2'b00;
    end else if (ce) begin
      if (wr_byte && paddr == TOC_OFS_CTRL1 && force_ok) begin
        force_level <= pwdata[TOC_FORCE_LSB +: 2]; // [R15] [R16]
      end else begin
        force_level <= 2'b00;
      end
    end
  end

  // only the fastest internal rate sees the counter without lag
  always_comb begin
    case (ctrl.clk_sel)
      TOC_CLK_DIV2: div2 = 1'b1; // [R13]
      TOC_CLK_DIV4: div2 = 1'b0; // [R14]
      TOC_CLK_DIV8: div2 = 1'b0; // [R14]
      TOC_CLK_EXT:  div2 = 1'b0; // [R22]
      default:      div2 = 1'b0;
    endcase
  end

  always_comb begin
    acc_one         = '0;
    acc_one.wr_hi   = wr_byte && paddr == TOC_OFS_C1_HIGH;
    acc_one.wr_lo   = wr_byte && paddr == TOC_OFS_C1_LOW;
    acc_one.acc_lo  = access && paddr == TOC_OFS_C1_LOW; // [R8]
    acc_one.sr_rd   = rd && paddr == TOC_OFS_STATUS;
    acc_one.sr_seen = prdata[0];
    acc_one.wdata   = pwdata[7:0];
    acc_two         = '0;
    acc_two.wr_hi   = wr_byte && paddr == TOC_OFS_C2_HIGH;
    acc_two.wr_lo   = wr_byte && paddr == TOC_OFS_C2_LOW;
    acc_two.acc_lo  = access && paddr == TOC_OFS_C2_LOW; // [R8]
    acc_two.sr_rd   = rd && paddr == TOC_OFS_STATUS;
    acc_two.sr_seen = prdata[1];
    acc_two.wdata   = pwdata[7:0];
  end

  toc_chan #(
    .DISABLED (1'b0)
  ) u_chan_one (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .acc         (acc_one),
    .count       (timer_count),
    .tick        (timer_tick),
    .div2        (div2),
    .pin_en      (ctrl.pin_en[0]),
    .level       (ctrl.level[0]),
    .force_pulse (force_level[0]),
    .value       (compare_value_one),
    .flag        (compare_match_flag[0]),
    .pin         (compare_output_pin[0])
  );

  toc_chan #(
    .DISABLED (REDUCED)
  ) u_chan_two (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .acc         (acc_two),
    .count       (timer_count),
    .tick        (timer_tick),
    .div2        (div2),
    .pin_en      (ctrl.pin_en[1]),
    .level       (ctrl.level[1]),
    .force_pulse (force_level[1]),
    .value       (compare_value_two),
    .flag        (compare_match_flag[1]),
    .pin         (compare_output_pin[1])
  );

  assign compare_pin_oe = ctrl.pin_en; // [R19]

  // pending request stays until both gates open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else if (ce) begin
      timer_irq <= ctrl.irq_en && !irq_mask && (|compare_match_flag); // [R5]
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence force_write_s;
    wr_byte && paddr == TOC_OFS_CTRL1 && pwdata[TOC_FORCE_LSB] && force_ok;
  endsequence

  sequence force_settle_s;
    ce [*2];
  endsequence

  irq_gate_a: assert property ((ce && timer_irq) |-> $past(ctrl.irq_en && !irq_mask)) // [R5]
    else $error("interrupt raised while gated");
  irq_raise_a: assert property ((ce && ctrl.irq_en && !irq_mask && |compare_match_flag)
    |=> timer_irq) // [R5]
    else $error("interrupt missing for pending flag");
  force_pin_a: assert property ((force_write_s ##0 force_settle_s) |=> compare_output_pin[0]
    == ctrl.level[0] || $past(timer_tick)) // [R15]
    else $error("forced level not on pin");
  force_noflag_a: assert property ((force_write_s ##0 !compare_match_flag[0] ##1
    !timer_tick [*2]) |-> !compare_match_flag[0]) // [R15]
    else $error("force set the match flag");
  force_mode_a: assert property ((ce && wr_byte && paddr == TOC_OFS_CTRL1 && !force_ok)
    |=> force_level == 2'b00) // [R16]
    else $error("force honoured in pulse or pwm mode");
  reduced_quiet_a: assert property (REDUCED |-> !compare_match_flag[1]) // [R17]
    else $error("second channel flag in reduced variant");
  unmapped_err_a: assert property ((setup && ce && !hit) |=> (pslverr || !penable)) // [R7]
    else $error("unmapped access without error");
  pin_dedicate_a: assert property ((ce && !ctrl.pin_en[0] && !force_level[0])
    |=> $stable(compare_output_pin[0])) // [R12]
    else $error("disabled pin changed on match");
  // the arm step trusts prdata, so it must carry the flags seen at setup
  status_view_a: assert property ((ce && setup && paddr == TOC_OFS_STATUS)
    |=> prdata[1:0] == $past(compare_match_flag)) // [R2]
    else $error("status read lost a flag");
  oe_store_a: assert property ((wr_byte && paddr == TOC_OFS_CTRL2)
    |=> compare_pin_oe == $past(pwdata[TOC_PIN_EN_LSB +: 2])) // [R19]
    else $error("pin enable not taken");
endmodule
`default_nettype wire

// File: tb/tb_timer_output_compare.sv
`timescale 1ns/1ns
`default_nettype none
module tb_timer_output_compare;
  import toc_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        err;
  } toc_row_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] timer_count = 16'h0;
  logic        timer_tick = 1'b0;
  logic        irq_mask = 1'b0;
  logic [1:0]  compare_output_pin;
  logic [1:0]  compare_pin_oe;
  logic        timer_irq;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] v;
  logic        err;
  logic [15:0] lag;
  toc_row_s    rows [7];

  toc_top #(.REDUCED(1'b0)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_count(timer_count),
    .timer_tick(timer_tick), .irq_mask(irq_mask), .compare_output_pin(compare_output_pin),
    .compare_pin_oe(compare_pin_oe), .timer_irq(timer_irq));

  always #2 pclk = ~pclk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // the run should need well under 2000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; an idle cycle always precedes setup so no signal is driven twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(what, v, e);
  endtask

  // counter value is fresh during the tick cycle only
  task automatic tick(input logic [15:0] c);
    @(posedge pclk);
    timer_count <= c;
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    rows = '{'{TOC_OFS_CTRL1, 32'h7, 32'h7, 1'b0}, '{TOC_OFS_CTRL2, 32'h3D, 32'h3D, 1'b0},
             '{TOC_OFS_C1_HIGH, 32'h12, 32'h12, 1'b0}, '{TOC_OFS_C1_LOW, 32'h34, 32'h34, 1'b0},
             '{TOC_OFS_C2_HIGH, 32'h56, 32'h56, 1'b0}, '{TOC_OFS_C2_LOW, 32'h78, 32'h78, 1'b0},
             '{8'h40, 32'hFF, 32'h0, 1'b1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      check("write error", {31'h0, err}, {31'h0, rows[i].err});
      apb(1'b0, rows[i].a, 32'h0);
      check("readback", v, rows[i].e);
      check("read error", {31'h0, err}, {31'h0, rows[i].err});
    end
    check("ready", {31'h0, pready}, 32'h1);
    $display("test register table done");
    apb(1'b1, TOC_OFS_C1_HIGH, 32'h2E);
    apb(1'b1, TOC_OFS_C1_LOW, 32'hD3);
    // level alternates so every pass moves the pin
    for (int s = 3; s >= 0; s--) begin
      lag = (s == 0) ? 16'h0 : TOC_MATCH_LAG;
      apb(1'b1, TOC_OFS_CTRL1, 32'h1 | (32'(s % 2) << 1));
      apb(1'b1, TOC_OFS_CTRL2, 32'h1 | (32'(s) << 2));
      tick(16'h2ED2 + lag);
      rd_chk("early flag", TOC_OFS_STATUS, 32'h0);
      tick(16'h2ED3 + lag);
      rd_chk("match flag", TOC_OFS_STATUS, 32'h1);
      check("pin level", {30'h0, compare_output_pin}, 32'(s % 2));
      check("pin oe", {30'h0, compare_pin_oe}, 32'h1);
      check("irq", {31'h0, timer_irq}, 32'h1);
      rd_chk("low byte", TOC_OFS_C1_LOW, 32'hD3);
      rd_chk("cleared flag", TOC_OFS_STATUS, 32'h0);
      check("irq off", {31'h0, timer_irq}, 32'h0);
    end
    $display("test clock select done");
    apb(1'b1, TOC_OFS_C1_HIGH, 32'h2E);
    tick(16'h2ED3);
    rd_chk("inhibited", TOC_OFS_STATUS, 32'h0);
    apb(1'b1, TOC_OFS_C1_LOW, 32'hD3);
    tick(16'h2ED3);
    rd_chk("re-enabled", TOC_OFS_STATUS, 32'h1);
    apb(1'b1, TOC_OFS_C1_LOW, 32'hD3);
    rd_chk("write clears", TOC_OFS_STATUS, 32'h0);
    $display("test inhibit done");
    apb(1'b1, TOC_OFS_CTRL2, 32'h0);
    apb(1'b1, TOC_OFS_CTRL1, 32'h3);
    irq_mask <= 1'b1;
    tick(16'h2ED3);
    check("pin untouched", {30'h0, compare_pin_oe, compare_output_pin}, 32'h0);
    check("masked irq", {31'h0, timer_irq}, 32'h0);
    irq_mask <= 1'b0;
    repeat (2) @(posedge pclk);
    check("unmasked irq", {31'h0, timer_irq}, 32'h1);
    rd_chk("flag set", TOC_OFS_STATUS, 32'h1);
    rd_chk("clear", TOC_OFS_C1_LOW, 32'hD3);
    $display("test pin disabled done");
    apb(1'b1, TOC_OFS_CTRL2, 32'h1);
    apb(1'b1, TOC_OFS_CTRL1, 32'hA);
    repeat (3) @(posedge pclk);
    check("forced pin", {30'h0, compare_output_pin}, 32'h1);
    rd_chk("force no flag", TOC_OFS_STATUS, 32'h0);
    check("force no irq", {31'h0, timer_irq}, 32'h0);
    // pulse mode then pwm mode: force must be ignored in both
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, TOC_OFS_CTRL2, 32'h1 | (32'h10 << m));
      apb(1'b1, TOC_OFS_CTRL1, 32'h8);
      repeat (3) @(posedge pclk);
      check("force ignored", {30'h0, compare_output_pin}, 32'h1);
    end
    $display("test force done");
    pstrb <= 4'h0;
    apb(1'b1, TOC_OFS_C1_HIGH, 32'h99);
    pstrb <= 4'hF;
    rd_chk("strobe off", TOC_OFS_C1_HIGH, 32'h2E);
    $display("test strobe done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("reset pins", {29'h0, timer_irq, compare_pin_oe, compare_output_pin}, 32'h0);
    presetn <= 1'b1;
    rd_chk("reset c1 high", TOC_OFS_C1_HIGH, 32'h80);
    rd_chk("reset c1 low", TOC_OFS_C1_LOW, 32'h00);
    rd_chk("reset c2 high", TOC_OFS_C2_HIGH, 32'h80);
    rd_chk("reset ctrl", TOC_OFS_CTRL1, 32'h0);
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire
